// ===== logic/lbt_consts.svh
`ifndef LBT_CONSTS_SVH
`define LBT_CONSTS_SVH
// APB register byte offsets
`define LBT_CTRL_OFF 12'h000
`define LBT_STAT_OFF 12'h004
`define LBT_ERRCNT_OFF 12'h008
// Control field positions
`define LBT_CTRL_LLOOP 0
`define LBT_CTRL_RLOOP 1
`define LBT_CTRL_PATEN 2
`define LBT_CTRL_PATERR 3
`define LBT_CTRL_RESET 32'h0000_0000
// Times in seconds and clock rate
`define LBT_CLK_HZ 25000000
`define LBT_PAT_TIMEOUT_S 45
`define LBT_RESTART_DATA_S 4
`define LBT_RESTART_LONG_S 60
`define LBT_RESTART_LOCAL_RDL_S 5
`define LBT_FLASH_S 1
`define LBT_PAT_TIMEOUT_CYC (`LBT_PAT_TIMEOUT_S * `LBT_CLK_HZ)
`define LBT_RESTART_DATA_CYC (`LBT_RESTART_DATA_S * `LBT_CLK_HZ)
`define LBT_RESTART_LONG_CYC (`LBT_RESTART_LONG_S * `LBT_CLK_HZ)
`define LBT_RESTART_RDL_CYC (`LBT_RESTART_LOCAL_RDL_S * `LBT_CLK_HZ)
`define LBT_FLASH_CYC (`LBT_FLASH_S * `LBT_CLK_HZ / 4)
// Out-of-band codes
`define LBT_OOB_NONE 2'h0
`define LBT_OOB_LOOP_ON 2'h1
`define LBT_OOB_LOOP_OFF 2'h2
`define LBT_OOB_ACK 2'h3
`endif

// ===== logic/lbt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbt_consts.svh"
module lbt_ctrl #(
  parameter int unsigned PAT_TIMEOUT_CYC = `LBT_PAT_TIMEOUT_CYC,
  parameter int unsigned RESTART_DATA_CYC = `LBT_RESTART_DATA_CYC,
  parameter int unsigned RESTART_LONG_CYC = `LBT_RESTART_LONG_CYC,
  parameter int unsigned RESTART_RDL_CYC = `LBT_RESTART_RDL_CYC,
  parameter int unsigned FLASH_CYC = `LBT_FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_local_loop,
  input wire logic sw_remote_loop,
  input wire logic [1:0] sw_pattern,
  input wire logic framed_rx,
  input wire logic line_up,
  input wire logic crc_error,
  input wire logic rx_bit,
  input wire lbt_pkg::lbt_oob_t oob_rx,
  output lbt_pkg::lbt_oob_t oob_tx,
  input wire logic oob_tx_done,
  output lbt_pkg::lbt_path_t path,
  output logic tx_bit,
  output logic restart,
  output logic no_signal_indicator,
  output logic error_indicator,
  output logic test_mode_indicator
);
  ////////////////////////////////////////////////////////////////////////
  lbt_pkg::lbt_state_t state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic [15:0] errcnt_reg;
  logic [31:0] prdata_reg;
  logic [31:0] pat_cnt_reg;
  logic [31:0] unf_cnt_reg;
  logic [31:0] flash_cnt_reg;
  logic [8:0] gen_reg;
  logic [8:0] det_reg;
  logic pat_run_reg, pat_done_reg, lock_reg, err_blink_reg, linked_reg;
  lbt_pkg::lbt_oob_t oob_tx_reg;
  lbt_pkg::lbt_path_t path_reg;
  logic tx_bit_reg, restart_reg;

  function automatic logic prbs_fb(input logic [8:0] s);
    prbs_fb = s[8] ^ s[4];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & ~penable & ~pwrite;
  wire hit_ctrl = paddr == `LBT_CTRL_OFF;
  wire hit_stat = paddr == `LBT_STAT_OFF;
  wire hit_err = paddr == `LBT_ERRCNT_OFF;
  wire hit_any = hit_ctrl | hit_stat | hit_err;
  wire [31:0] stat_word = {24'h0, linked_reg, lock_reg, pat_done_reg,
    pat_run_reg, state_reg, 1'b0};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg :
    hit_stat ? stat_word : hit_err ? {16'h0, errcnt_reg} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Requests from switches, DTE control word
  wire req_local = sw_local_loop | ctrl_reg[`LBT_CTRL_LLOOP];
  wire req_remote = sw_remote_loop | ctrl_reg[`LBT_CTRL_RLOOP];
  wire pat_sw = (sw_pattern != 2'h0) | ctrl_reg[`LBT_CTRL_PATEN];
  wire pat_inject = sw_pattern[1] | ctrl_reg[`LBT_CTRL_PATERR];
  wire far_on = oob_rx.valid && oob_rx.code == `LBT_OOB_LOOP_ON;
  wire far_off = oob_rx.valid && oob_rx.code == `LBT_OOB_LOOP_OFF;
  wire far_ack = oob_rx.valid && oob_rx.code == `LBT_OOB_ACK;
  wire loop2 = state_reg == lbt_pkg::LBT_LOOP2;
  // Generator is allowed except in variant 2 and after a timeout, until the pattern request clears
  wire pat_allow = pat_sw & ~loop2 & ~pat_done_reg;
  wire pat_start = pat_allow & ~pat_run_reg;
  wire far_end = state_reg == lbt_pkg::LBT_RL_FAR;

  ////////////////////////////////////////////////////////////////////////
  // Test mode sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lbt_pkg::LBT_IDLE: begin
        if (lock_reg) begin
          state_next = lbt_pkg::LBT_IDLE;
        end else if (req_local) begin
          state_next = linked_reg ? lbt_pkg::LBT_LOOP2
            : lbt_pkg::LBT_LOOP1;
        end else if (req_remote) begin
          state_next = lbt_pkg::LBT_RL_REQ;
        end else if (far_on) begin
          state_next = lbt_pkg::LBT_RL_FAR;
        end
      end
      lbt_pkg::LBT_LOOP1, lbt_pkg::LBT_LOOP2: begin
        if (!req_local) state_next = lbt_pkg::LBT_IDLE;
      end
      lbt_pkg::LBT_RL_REQ: begin
        if (!req_remote) state_next = lbt_pkg::LBT_RL_OFF;
        else if (far_ack) state_next = lbt_pkg::LBT_RL_ON;
      end
      lbt_pkg::LBT_RL_ON: begin
        if (!req_remote) state_next = lbt_pkg::LBT_RL_OFF;
      end
      lbt_pkg::LBT_RL_OFF: begin
        if (oob_tx_done) state_next = lbt_pkg::LBT_IDLE;
      end
      lbt_pkg::LBT_RL_FAR: begin
        if (far_off) state_next = lbt_pkg::LBT_IDLE;
      end
      default: state_next = lbt_pkg::LBT_IDLE;
    endcase
  end

  // Restart limit follows mode; long limit while own pattern runs
  wire [31:0] restart_lim = (pat_run_reg | far_end) ? RESTART_LONG_CYC
    : (state_reg == lbt_pkg::LBT_RL_ON) ? RESTART_RDL_CYC
    : RESTART_DATA_CYC;
  wire no_frames = ~framed_rx | ~line_up;
  wire restart_hit = linked_reg & no_frames & (unf_cnt_reg >= restart_lim);
  // Self-synchronising: history is the received bits themselves
  wire det_expect = prbs_fb(det_reg);
  wire bit_err = pat_run_reg & (rx_bit != det_expect);
  wire flash_tick = flash_cnt_reg >= FLASH_CYC - 1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= lbt_pkg::LBT_IDLE;
      ctrl_reg <= `LBT_CTRL_RESET;
      prdata_reg <= 32'h0;
      lock_reg <= 1'b0;
      linked_reg <= 1'b0;
    end else begin
      state_reg <= restart_hit ? lbt_pkg::LBT_IDLE : state_next;
      if (apb_wr && hit_ctrl) ctrl_reg <= pwdata;
      if (apb_rd) prdata_reg <= rd_mux;
      if (state_reg == lbt_pkg::LBT_RL_OFF && req_remote)
        lock_reg <= 1'b1;
      else if (!req_remote && state_reg != lbt_pkg::LBT_RL_OFF)
        lock_reg <= 1'b0;
      if (restart_hit || state_reg == lbt_pkg::LBT_LOOP1)
        linked_reg <= 1'b0;
      else if (framed_rx && line_up)
        linked_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern generator, detector and timers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_run_reg <= 1'b0;
      pat_done_reg <= 1'b0;
      pat_cnt_reg <= 32'h0;
      unf_cnt_reg <= 32'h0;
      gen_reg <= 9'h1FF;
      det_reg <= 9'h1FF;
      errcnt_reg <= 16'h0;
    end else begin
      // Clear first so a timeout in the same cycle wins
      if (!pat_sw) pat_done_reg <= 1'b0;
      if (pat_start) begin
        pat_run_reg <= 1'b1;
        pat_cnt_reg <= 32'h0;
      end else if (pat_run_reg && pat_cnt_reg >= PAT_TIMEOUT_CYC - 1) begin
        pat_run_reg <= 1'b0;
        pat_done_reg <= 1'b1;
      end else if (pat_run_reg && !pat_allow) begin
        pat_run_reg <= 1'b0;
      end else begin
        pat_cnt_reg <= pat_cnt_reg + 32'h1;
      end
      unf_cnt_reg <= no_frames ? unf_cnt_reg + 32'h1 : 32'h0;
      gen_reg <= {gen_reg[7:0], prbs_fb(gen_reg)};
      det_reg <= {det_reg[7:0], rx_bit};
      if (bit_err && errcnt_reg != 16'hFFFF)
        errcnt_reg <= errcnt_reg + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data paths, out-of-band channel and indicators
  wire st_loop1 = state_reg == lbt_pkg::LBT_LOOP1;
  wire st_rl = state_reg == lbt_pkg::LBT_RL_ON;
  // Injected error flips one bit per sequence period
  wire gen_out = prbs_fb(gen_reg) ^ (pat_inject & (gen_reg == 9'h1FF));
  lbt_pkg::lbt_path_t path_next;
  assign path_next.local_to_local = st_loop1 | loop2;
  assign path_next.framer_local_loop = loop2;
  assign path_next.far_to_line = far_end | loop2;
  assign path_next.pass_to_dte = ~pat_run_reg & ~st_loop1;
  assign path_next.ignore_dte_tx = far_end;
  assign path_next.pattern_to_line = pat_run_reg & ~st_loop1;
  assign path_next.pattern_to_loop = pat_run_reg & st_loop1;
  wire [1:0] oob_code = (state_reg == lbt_pkg::LBT_RL_REQ) ? `LBT_OOB_LOOP_ON
    : (state_reg == lbt_pkg::LBT_RL_OFF) ? `LBT_OOB_LOOP_OFF
    : (far_end && far_on) ? `LBT_OOB_ACK : `LBT_OOB_NONE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      path_reg <= '0;
      oob_tx_reg <= '0;
      tx_bit_reg <= 1'b0;
      restart_reg <= 1'b0;
      flash_cnt_reg <= 32'h0;
      err_blink_reg <= 1'b0;
    end else begin
      path_reg <= path_next;
      oob_tx_reg.code <= oob_code;
      oob_tx_reg.valid <= oob_code != `LBT_OOB_NONE;
      tx_bit_reg <= gen_out;
      restart_reg <= restart_hit;
      flash_cnt_reg <= flash_tick ? 32'h0 : flash_cnt_reg + 32'h1;
      if (crc_error || bit_err)
        err_blink_reg <= 1'b1;
      else if (pat_done_reg && flash_tick)
        err_blink_reg <= ~err_blink_reg;
      else if (flash_tick)
        err_blink_reg <= 1'b0;
    end
  end

  assign path = path_reg;
  assign oob_tx = oob_tx_reg;
  assign tx_bit = tx_bit_reg;
  assign restart = restart_reg;
  assign no_signal_indicator = ~linked_reg;
  assign error_indicator = err_blink_reg;
  // Indicator lit in any test state, including release in flight
  assign test_mode_indicator = (state_reg != lbt_pkg::LBT_IDLE)
    | pat_run_reg;

  ////////////////////////////////////////////////////////////////////////
  a_loop_variant: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == lbt_pkg::LBT_IDLE && !lock_reg && req_local && !restart_hit
    |=> state_reg == ($past(linked_reg) ? lbt_pkg::LBT_LOOP2
    : lbt_pkg::LBT_LOOP1)) else $error("bad loop variant");
  a_no_gen_loop2: assert property (@(posedge clk) disable iff (!rst_b)
    loop2 |-> !pat_start) else $error("generator in loop 2");
  a_tm_release: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == lbt_pkg::LBT_RL_OFF |-> test_mode_indicator)
    else $error("indicator dark before release sent");
  a_offreq_sent: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == lbt_pkg::LBT_RL_OFF ##1 state_reg == lbt_pkg::LBT_RL_OFF
    |-> oob_tx.code == `LBT_OOB_LOOP_OFF) else $error("no release");
  a_lock_hold: assert property (@(posedge clk) disable iff (!rst_b)
    lock_reg && state_reg == lbt_pkg::LBT_IDLE && !restart_hit
    |=> state_reg == lbt_pkg::LBT_IDLE) else $error("locked switch used");
  a_pat_dte: assert property (@(posedge clk) disable iff (!rst_b)
    $past(pat_run_reg) |-> !path.pass_to_dte)
    else $error("pattern reaches dte");
  a_far_path: assert property (@(posedge clk) disable iff (!rst_b)
    far_end |=> path.far_to_line && path.ignore_dte_tx)
    else $error("far loop path");
  a_long_restart: assert property (@(posedge clk) disable iff (!rst_b)
    pat_run_reg |-> restart_lim == RESTART_LONG_CYC)
    else $error("restart not lengthened");
endmodule
`default_nettype wire

// ===== logic/lbt_pkg.sv
package lbt_pkg;
  typedef enum logic [2:0] {
    LBT_IDLE = 3'b000,
    LBT_LOOP1 = 3'b001,
    LBT_LOOP2 = 3'b010,
    LBT_RL_REQ = 3'b011,
    LBT_RL_ON = 3'b100,
    LBT_RL_OFF = 3'b101,
    LBT_RL_FAR = 3'b110
  } lbt_state_t;

  typedef struct packed {
    logic [1:0] code;
    logic valid;
  } lbt_oob_t;

  typedef struct packed {
    logic local_to_local;
    logic framer_local_loop;
    logic far_to_line;
    logic pass_to_dte;
    logic ignore_dte_tx;
    logic pattern_to_line;
    logic pattern_to_loop;
  } lbt_path_t;
endpackage

// ===== testbench/lbt_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbt_consts.svh"
module lbt_remote_model #(
  parameter int ACK_DLY = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_en,
  input wire logic framed_en,
  input wire lbt_pkg::lbt_oob_t oob_tx,
  input wire logic tx_bit,
  output lbt_pkg::lbt_oob_t oob_rx,
  output logic oob_tx_done,
  output logic line_up,
  output logic framed_rx,
  output logic rx_bit
);
  logic [7:0] cnt_reg;
  logic acked_reg;
  wire on_req = oob_tx.valid && oob_tx.code == `LBT_OOB_LOOP_ON;
  wire off_req = oob_tx.valid && oob_tx.code == `LBT_OOB_LOOP_OFF;
  ////////////////////////////////////////////////////////////////////////
  // Answers late on purpose so the waiting phases are visible
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 8'h00;
      acked_reg <= 1'b0;
      oob_rx <= '0;
      oob_tx_done <= 1'b0;
    end else begin
      oob_rx.valid <= 1'b0;
      oob_rx.code <= ~oob_rx.code;
      oob_tx_done <= 1'b0;
      cnt_reg <= 8'h00;
      if (on_req && !acked_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == 8'(ACK_DLY)) begin
          oob_rx.code <= `LBT_OOB_ACK;
          oob_rx.valid <= 1'b1;
          acked_reg <= 1'b1;
        end
      end else if (off_req) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == 8'(ACK_DLY)) begin
          oob_tx_done <= 1'b1;
          acked_reg <= 1'b0;
        end
      end
    end
  end
  // Dead line toggles instead of holding the last bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_bit <= 1'b0;
      line_up <= 1'b0;
      framed_rx <= 1'b0;
    end else begin
      rx_bit <= link_en ? tx_bit : ~rx_bit;
      line_up <= link_en;
      framed_rx <= link_en & framed_en;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/loopback_and_prbs_test_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbt_consts.svh"
module loopback_and_prbs_test_control_tb;
  localparam int PAT = 200;
  localparam int RDATA = 40;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, sw_l, sw_r, crc_error, line_up, framed_rx, rx_bit, tx_bit;
  logic restart, no_signal_indicator, error_indicator, test_mode_indicator;
  logic link_en, framed_en, oob_tx_done;
  logic [1:0] sw_pattern;
  lbt_pkg::lbt_oob_t oob_rx, oob_tx;
  lbt_pkg::lbt_path_t path;
  int fail_count, n_checks, cyc, nrst, ntog;
  lbt_ctrl #(.PAT_TIMEOUT_CYC(PAT), .RESTART_DATA_CYC(RDATA),
    .RESTART_LONG_CYC(600), .RESTART_RDL_CYC(50), .FLASH_CYC(10)) DUT (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sw_local_loop(sw_l),
    .sw_remote_loop(sw_r), .sw_pattern(sw_pattern), .framed_rx(framed_rx),
    .line_up(line_up), .crc_error(crc_error), .rx_bit(rx_bit),
    .oob_rx(oob_rx), .oob_tx(oob_tx), .oob_tx_done(oob_tx_done),
    .path(path), .tx_bit(tx_bit), .restart(restart),
    .no_signal_indicator(no_signal_indicator),
    .error_indicator(error_indicator),
    .test_mode_indicator(test_mode_indicator));
  lbt_remote_model far (.clk(clk), .rst_b(rst_b), .link_en(link_en),
    .framed_en(framed_en), .oob_tx(oob_tx), .tx_bit(tx_bit),
    .oob_rx(oob_rx), .oob_tx_done(oob_tx_done), .line_up(line_up),
    .framed_rx(framed_rx), .rx_bit(rx_bit));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard well above the longest wait in the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task watch(input int n);
    logic last;
    nrst = 0;
    ntog = 0;
    last = error_indicator;
    repeat (n) begin
      @(posedge clk);
      if (restart === 1'b1) nrst++;
      if (error_indicator !== last) ntog++;
      last = error_indicator;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sw_l, sw_r} = '0;
    {sw_pattern, crc_error, link_en, framed_en, cyc} = '0;
    {fail_count, n_checks, rst_b} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `LBT_CTRL_OFF, 32'h0);
    chk(rd, `LBT_CTRL_RESET);
    apb(1'b1, `LBT_CTRL_OFF, 32'h0000_0008);
    apb(1'b0, `LBT_CTRL_OFF, 32'h0);
    chk(rd, 32'h0000_0008);
    apb(1'b1, `LBT_CTRL_OFF, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd, err}, 33'h0_0000_0001);
    $display("register test done");
    chk(no_signal_indicator, 1'b1);
    sw_l <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `LBT_STAT_OFF, 32'h0);
    chk(rd[3:1], lbt_pkg::LBT_LOOP1);
    chk(path.local_to_local, 1'b1);
    sw_pattern <= 2'h1;
    repeat (3) @(posedge clk);
    chk(path.pattern_to_loop, 1'b1);
    chk(path.pass_to_dte, 1'b0);
    {sw_pattern, sw_l} <= '0;
    link_en <= 1'b1;
    framed_en <= 1'b1;
    while (no_signal_indicator !== 1'b0) @(posedge clk);
    sw_l <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `LBT_STAT_OFF, 32'h0);
    chk(rd[3:1], lbt_pkg::LBT_LOOP2);
    chk({path.framer_local_loop, path.far_to_line}, 2'b11);
    sw_pattern <= 2'h1;
    repeat (3) @(posedge clk);
    chk(path.pattern_to_line, 1'b0);
    {sw_pattern, sw_l} <= '0;
    repeat (3) @(posedge clk);
    apb(1'b0, `LBT_STAT_OFF, 32'h0);
    chk({rd[3:1], path.framer_local_loop}, 4'h0);
    $display("local loop test done");
    sw_r <= 1'b1;
    repeat (3) @(posedge clk);
    chk(oob_tx, {`LBT_OOB_LOOP_ON, 1'b1});
    while (oob_tx.valid === 1'b1) @(posedge clk);
    chk(test_mode_indicator, 1'b1);
    apb(1'b0, `LBT_STAT_OFF, 32'h0);
    chk(rd[3:1], lbt_pkg::LBT_RL_ON);
    sw_r <= 1'b0;
    repeat (3) @(posedge clk);
    chk(oob_tx, {`LBT_OOB_LOOP_OFF, 1'b1});
    chk(test_mode_indicator, 1'b1);
    sw_r <= 1'b1;
    while (oob_tx.valid === 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(test_mode_indicator, 1'b0);
    apb(1'b0, `LBT_STAT_OFF, 32'h0);
    chk(rd[3:1], lbt_pkg::LBT_IDLE);
    sw_r <= 1'b0;
    $display("remote loop test done");
    sw_pattern <= 2'h1;
    repeat (3) @(posedge clk);
    chk({path.pattern_to_line, path.pass_to_dte}, 2'b10);
    framed_en <= 1'b0;
    watch(100);
    chk(nrst, 0);
    framed_en <= 1'b1;
    repeat (PAT) @(posedge clk);
    apb(1'b0, `LBT_STAT_OFF, 32'h0);
    chk({rd[5:4], path.pattern_to_line}, 3'b100);
    watch(40);
    chk(ntog > 2, 1'b1);
    sw_pattern <= 2'h0;
    repeat (3) @(posedge clk);
    apb(1'b0, `LBT_STAT_OFF, 32'h0);
    chk(rd[5], 1'b0);
    $display("pattern test done");
    crc_error <= 1'b1;
    @(posedge clk);
    crc_error <= 1'b0;
    watch(4);
    chk(ntog > 0, 1'b1);
    framed_en <= 1'b0;
    watch(RDATA + 6);
    chk(nrst, 1);
    $display("restart test done");
    stop_test();
  end
endmodule
`default_nettype wire
